// ### design/sbsr_pkg.sv
// Purpose: shared constants and types for the status byte / service request block
// Assumes: 8-bit status byte and standard event latch
// Notes:   error codes are signed 16-bit values
package sbsr_pkg;
    // ---------------------------------------------------------------
    // widths
    // ---------------------------------------------------------------
    localparam int unsigned REG_W = 8;                 // width of every register
    localparam int unsigned CODE_W = 16;               // error code width
    typedef logic [REG_W-1:0] sbsr_byte_t;             // one register byte
    typedef logic signed [CODE_W-1:0] sbsr_code_t;     // error queue code

    // ---------------------------------------------------------------
    // status byte bit positions
    // ---------------------------------------------------------------
    localparam int unsigned SSB_ERRQ = 2;              // error queue not empty
    localparam int unsigned SSB_QUES = 3;              // questionable summary
    localparam int unsigned SSB_MSG = 4;               // message available
    localparam int unsigned SSB_SEV = 5;               // standard event summary
    localparam int unsigned SSB_MAIN = 6;              // main summary
    localparam int unsigned SSB_OPER = 7;              // operation summary

    // ---------------------------------------------------------------
    // standard event latch bit positions
    // ---------------------------------------------------------------
    localparam int unsigned SEL_OPC = 0;               // operation complete
    localparam int unsigned SEL_QYE = 2;               // query error
    localparam int unsigned SEL_DDE = 3;               // device dependent error
    localparam int unsigned SEL_EXE = 4;               // execution error
    localparam int unsigned SEL_CME = 5;               // command error
    localparam int unsigned SEL_URQ = 6;               // user request
    localparam int unsigned SEL_PON = 7;               // power on

    // ---------------------------------------------------------------
    // reset values and used-bit masks
    // ---------------------------------------------------------------
    localparam sbsr_byte_t MASK_RST = 8'h00;           // masks after reset
    localparam sbsr_byte_t SEL_RST = 8'h80;            // latch after reset: power on
    localparam sbsr_byte_t SSB_USED = 8'hFC;           // bits 0 and 1 unused
    localparam sbsr_byte_t SEL_USED = 8'hFD;           // bit 1 unused
    localparam sbsr_byte_t SRM_REQ_MASK = 8'hBF;       // bit 6 ignored in requests

    // ---------------------------------------------------------------
    // error code ranges
    // ---------------------------------------------------------------
    localparam sbsr_code_t CME_CODE = -16'sd100;       // command error code
    localparam sbsr_code_t EXE_CODE = -16'sd200;       // execution error code
    localparam sbsr_code_t QYE_CODE = -16'sd400;       // query error code
    localparam sbsr_code_t DDE_LO = -16'sd399;         // device error lowest
    localparam sbsr_code_t DDE_HI = -16'sd300;         // device error highest

    // ---------------------------------------------------------------
    // command access kinds
    // ---------------------------------------------------------------
    typedef enum logic [2:0]
    {
        SBSR_CMD_NONE     = 3'b000,
        SBSR_CMD_RD_SSB   = 3'b001,
        SBSR_CMD_POLL     = 3'b010,
        SBSR_CMD_WR_SRM   = 3'b011,
        SBSR_CMD_RD_SRM   = 3'b100,
        SBSR_CMD_WR_SEM   = 3'b101,
        SBSR_CMD_RD_SEM   = 3'b110,
        SBSR_CMD_RD_SEL   = 3'b111
    } sbsr_cmd_e;
endpackage

// ### design/sbsr_evt_if.sv
// Purpose: carries standard event pulses into the latch
// Assumes: single clock domain
// Notes:   one-cycle pulses, one bit per latch position
`timescale 1ns/1ps
`default_nettype none
interface sbsr_evt_if;
    logic [7:0] set;     // per-bit set pulses
    logic       clr;     // read-and-clear strobe
    logic [7:0] value;   // latch contents
    modport src (output set, output clr, input value);
    modport dst (input set, input clr, output value);
endinterface
`default_nettype wire

// ### design/sbsr_event_latch.sv
// Purpose: sticky event latch with read-to-clear
// Assumes: set pulses from the same clock
// Notes:   a set in the clear cycle survives the clear
`timescale 1ns/1ps
`default_nettype none
module sbsr_event_latch
    import sbsr_pkg::*;
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // event side
    sbsr_evt_if.dst   evt
);
    sbsr_byte_t lat_q; // latched events

    // ---------------------------------------------------------------
    // latch: set beats clear, unused bit held at zero
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            lat_q <= SEL_RST; // power on event recorded
        end
        else if (evt.clr)
        begin
            lat_q <= evt.set & SEL_USED; // read clears, new events kept
        end
        else
        begin
            lat_q <= (lat_q | evt.set) & SEL_USED;
        end
    end

    assign evt.value = lat_q;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sticky_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (|(evt.set & SEL_USED)) |=> ((lat_q & $past(evt.set) & SEL_USED) == ($past(evt.set) & SEL_USED)))
        else $error("event set lost");
    unused_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
        lat_q[1] == 1'b0)
        else $error("unused latch bit set");
endmodule // sbsr_event_latch
`default_nettype wire

// ### design/sbsr_top.sv
// Purpose: status byte, service request mask and standard event latch
// Assumes: commands decoded upstream into one-cycle access pulses
// Notes:   answers are registered one cycle after the access
`timescale 1ns/1ps
`default_nettype none
module sbsr_top
    import sbsr_pkg::*;
(
    // clock and reset
    input  wire logic            i_clk,
    input  wire logic            i_rst,
    // command access
    input  wire sbsr_pkg::sbsr_cmd_e i_cmd,
    input  wire logic            i_cmd_valid,
    input  wire logic [7:0]      i_wdata,
    output var  logic [7:0]      o_rdata,
    output var  logic            o_rvalid,
    // summaries from lower registers and queues
    input  wire logic            i_errq_push,
    input  wire logic            i_errq_empty,
    input  wire logic            i_ques_sum,
    input  wire logic            i_oper_sum,
    input  wire logic            i_msg_avail,
    // standard event sources
    input  wire logic            i_opc_cmd,
    input  wire logic            i_cmds_idle,
    input  wire logic            i_read_no_query,
    input  wire logic            i_unread_overrun,
    input  wire logic            i_dev_err,
    input  wire logic            i_exe_err,
    input  wire logic            i_cmd_err,
    input  wire logic            i_go_local,
    // error queue entry
    output var  logic            o_err_push,
    output var  logic [15:0]     o_err_code,
    // service request
    output var  logic            o_srq
);
    import sbsr_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    sbsr_byte_t srm_q;          // service request mask
    sbsr_byte_t sem_q;          // standard event mask
    sbsr_byte_t ssb_q;          // registered status byte
    sbsr_byte_t ssb_d;          // next status byte
    sbsr_byte_t sel_prev_q;     // latch value one cycle ago
    logic       sev_q;          // standard event summary
    logic       errq_q;         // error queue not empty
    logic       opc_pend_q;     // operation complete waiting
    logic       srq_q;          // service request pulse
    logic [7:0] rdata_q;        // answer data
    logic       rvalid_q;       // answer strobe
    logic       push_q;         // error queue push
    sbsr_code_t code_q;         // error queue code
    logic       rd_sel;         // latch read this cycle

    sbsr_evt_if evt ();         // event latch link

    assign rd_sel = i_cmd_valid && (i_cmd == SBSR_CMD_RD_SEL);

    // ---------------------------------------------------------------
    // standard event set pulses
    // ---------------------------------------------------------------
    always_comb
    begin
        evt.set = '0;
        evt.set[SEL_OPC] = opc_pend_q && i_cmds_idle;
        evt.set[SEL_QYE] = i_read_no_query || i_unread_overrun;
        evt.set[SEL_DDE] = i_dev_err;
        evt.set[SEL_EXE] = i_exe_err;
        evt.set[SEL_CME] = i_cmd_err;
        evt.set[SEL_URQ] = i_go_local;
    end
    assign evt.clr = rd_sel;

    sbsr_event_latch u_latch
    (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .evt   (evt.dst)
    );

    // ---------------------------------------------------------------
    // operation complete waits for prior commands
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            opc_pend_q <= 1'b0;
        end
        else if (i_opc_cmd)
        begin
            opc_pend_q <= 1'b1;
        end
        else if (i_cmds_idle)
        begin
            opc_pend_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // error queue codes for each error kind
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            push_q <= 1'b0;
            code_q <= '0;
        end
        else
        begin
            push_q <= i_cmd_err || i_exe_err || i_dev_err || evt.set[SEL_QYE];
            if (i_cmd_err)
            begin
                code_q <= CME_CODE;
            end
            else if (i_exe_err)
            begin
                code_q <= EXE_CODE;
            end
            else if (i_dev_err)
            begin
                code_q <= DDE_HI;
            end
            else if (evt.set[SEL_QYE])
            begin
                code_q <= QYE_CODE;
            end
        end
    end

    // ---------------------------------------------------------------
    // masks written by set commands
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            srm_q <= MASK_RST;
            sem_q <= MASK_RST;
        end
        else if (i_cmd_valid)
        begin
            if (i_cmd == SBSR_CMD_WR_SRM)
            begin
                srm_q <= i_wdata;
            end
            if (i_cmd == SBSR_CMD_WR_SEM)
            begin
                sem_q <= i_wdata;
            end
        end
    end

    // ---------------------------------------------------------------
    // standard event summary: set while any masked latch bit is set, drops when cleared
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            sel_prev_q <= SEL_RST;
            sev_q      <= 1'b0;
            errq_q     <= 1'b0;
        end
        else
        begin
            sel_prev_q <= evt.value;
            sev_q      <= |(evt.value & sem_q & SEL_USED);
            errq_q     <= i_errq_push || (errq_q && !i_errq_empty);
        end
    end

    // ---------------------------------------------------------------
    // status byte assembly
    // ---------------------------------------------------------------
    always_comb
    begin
        ssb_d = '0;
        ssb_d[SSB_ERRQ] = errq_q;
        ssb_d[SSB_QUES] = i_ques_sum;
        ssb_d[SSB_MSG]  = i_msg_avail;
        ssb_d[SSB_SEV]  = sev_q;
        ssb_d[SSB_OPER] = i_oper_sum;
        ssb_d[SSB_MAIN] = |(ssb_d & srm_q & SRM_REQ_MASK);
        ssb_d = ssb_d & SSB_USED;
    end

    // bit two only rises after a push, which already raised its own request;
    // leaving it out of the rise term keeps one request per queue entry
    localparam sbsr_byte_t RISE_MASK = SRM_REQ_MASK & ~(sbsr_byte_t'(1) << SSB_ERRQ);

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            ssb_q <= '0;
            srq_q <= 1'b0;
        end
        else
        begin
            ssb_q <= ssb_d;
            // a fresh masked rise, or a new queue entry while masked in
            srq_q <= |(ssb_d & ~ssb_q & srm_q & RISE_MASK)
                  || (i_errq_push && srm_q[SSB_ERRQ]);
        end
    end

    // ---------------------------------------------------------------
    // answers to read accesses
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            rdata_q  <= '0;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= 1'b0;
            if (i_cmd_valid)
            begin
                unique case (i_cmd)
                    SBSR_CMD_RD_SSB, SBSR_CMD_POLL:
                    begin
                        rdata_q  <= ssb_q;
                        rvalid_q <= 1'b1;
                    end
                    SBSR_CMD_RD_SRM:
                    begin
                        rdata_q  <= srm_q;
                        rvalid_q <= 1'b1;
                    end
                    SBSR_CMD_RD_SEM:
                    begin
                        rdata_q  <= sem_q;
                        rvalid_q <= 1'b1;
                    end
                    SBSR_CMD_RD_SEL:
                    begin
                        rdata_q  <= evt.value;
                        rvalid_q <= 1'b1;
                    end
                    SBSR_CMD_NONE, SBSR_CMD_WR_SRM, SBSR_CMD_WR_SEM:
                    begin
                        rvalid_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    assign o_rdata    = rdata_q;
    assign o_rvalid   = rvalid_q;
    assign o_srq      = srq_q;
    assign o_err_push = push_q;
    assign o_err_code = code_q;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    main_summary_a: assert property (@(posedge i_clk) disable iff (i_rst)
        ssb_q[SSB_MAIN] == |(ssb_q & $past(srm_q) & SRM_REQ_MASK))
        else $error("main summary wrong");
    mask_six_a: assert property (@(posedge i_clk) disable iff (i_rst)
        ((srm_q & SRM_REQ_MASK) == 8'h00) |=> (!o_srq && !ssb_q[SSB_MAIN]))
        else $error("request with only bit six in mask");
    srq_rise_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_ques_sum && !$past(i_ques_sum) && srm_q[SSB_QUES] && $stable(srm_q)) |=> o_srq)
        else $error("no request on masked rise");
    errq_bit_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_errq_push |=> ##1 ssb_q[SSB_ERRQ])
        else $error("error queue bit missing");
    errq_srq_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_errq_push && srm_q[SSB_ERRQ]) |=> o_srq)
        else $error("no request for queue entry");
    sev_follow_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (|(evt.value & sem_q)) |=> sev_q)
        else $error("event summary missing");
    sev_rise_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (|(evt.value & ~sel_prev_q & sem_q)) |=> ##1 ssb_q[SSB_SEV])
        else $error("latch rise lost in summary");
    opc_wait_a: assert property (@(posedge i_clk) disable iff (i_rst)
        evt.set[SEL_OPC] |-> i_cmds_idle)
        else $error("opc before idle");
    rd_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (rd_sel && !(|evt.set)) |=> evt.value == 8'h00)
        else $error("latch not cleared by read");
    unused_ssb_a: assert property (@(posedge i_clk) disable iff (i_rst)
        ssb_q[1:0] == 2'b00)
        else $error("unused status bits set");
    sel_answer_a: assert property (@(posedge i_clk) disable iff (i_rst)
        rd_sel |=> (o_rvalid && o_rdata == $past(evt.value)))
        else $error("latch answer wrong");

    // ---------------------------------------------------------------
    // checks: answers, mask writes and error codes
    // ---------------------------------------------------------------
    poll_answer_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_cmd_valid && i_cmd == SBSR_CMD_POLL) |=> (o_rvalid && o_rdata == $past(ssb_q)))
        else $error("poll answer wrong");
    srm_answer_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_cmd_valid && i_cmd == SBSR_CMD_RD_SRM) |=> (o_rvalid && o_rdata == $past(srm_q)))
        else $error("request mask answer wrong");
    sem_write_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_cmd_valid && i_cmd == SBSR_CMD_WR_SEM) |=> (sem_q == $past(i_wdata)))
        else $error("event mask write lost");
    cme_code_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_cmd_err |=> (o_err_push && o_err_code == CME_CODE))
        else $error("command error code wrong");

    srq_seen_c: cover property (@(posedge i_clk) o_srq);
    poll_c: cover property (@(posedge i_clk) i_cmd_valid && i_cmd == SBSR_CMD_POLL);
    sev_c: cover property (@(posedge i_clk) ssb_q[SSB_SEV]);
    errq_srq_c: cover property (@(posedge i_clk) i_errq_push && srm_q[SSB_ERRQ]);
endmodule // sbsr_top
`default_nettype wire

// ### testbench/sbsr_ctrl_model.sv
// Purpose: remote controller model issuing common commands and serial polls
// Assumes: one access at a time, answer registered on the taking edge
// Notes:   released command lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module sbsr_ctrl_model
    import sbsr_pkg::*;
(
    // clock
    input  wire logic                i_clk,
    // answer from the device
    input  wire logic [7:0]          i_rdata,
    input  wire logic                i_rvalid,
    // command access toward the device
    output var  sbsr_pkg::sbsr_cmd_e o_cmd,
    output var  logic                o_cmd_valid,
    output var  logic [7:0]          o_wdata
);
    // ---------------------------------------------------------------
    // idle state at time zero
    // ---------------------------------------------------------------
    initial
    begin
        o_cmd       = SBSR_CMD_NONE;
        o_cmd_valid = 1'b0;
        o_wdata     = 8'h00;
    end

    // one access: drive after the edge, hold through the taking edge, then release
    task automatic access(input sbsr_cmd_e cmd, input logic [7:0] wdata, output logic [7:0] rdata);
        @(posedge i_clk);
        #1;
        o_cmd       = cmd;
        o_wdata     = wdata;
        o_cmd_valid = 1'b1;
        @(posedge i_clk);
        #1;
        o_cmd_valid = 1'b0;
        o_cmd       = sbsr_cmd_e'(~cmd);
        o_wdata     = ~wdata;
        // read kinds answer in this cycle; writes give nothing back
        rdata = (i_rvalid === 1'b1) ? i_rdata : 8'hxx;
    endtask
endmodule // sbsr_ctrl_model
`default_nettype wire

// ### testbench/sbsr_top_bench.sv
// Purpose: self-checking bench for the status byte and service request block
// Assumes: controller model issues accesses, bench drives event sources
// Notes:   event sources pulse one cycle, summary levels change slowly
`timescale 1ns/1ps
`default_nettype none
module sbsr_top_bench;
    import sbsr_pkg::*;
    // ---------------------------------------------------------------
    // signals
    // ---------------------------------------------------------------
    logic        i_clk      = 1'b0;   // 100 MHz clock
    logic        i_rst      = 1'b1;   // sync reset, held 3 cycles
    sbsr_cmd_e   cmd;                 // access kind from the model
    logic        cmd_valid;           // access strobe from the model
    logic [7:0]  wdata;               // mask data from the model
    logic [7:0]  rdata;               // answer data
    logic        rvalid;              // answer strobe
    logic        err_push;            // error queue entry strobe
    logic        srq;                 // service request pulse
    logic [15:0] err_code;            // error queue code
    logic        errq_push  = 1'b0;   // error queue entry made
    logic        errq_empty = 1'b1;   // error queue empty
    logic        opc        = 1'b0;   // operation-complete command
    logic        idle       = 1'b1;   // earlier commands finished
    logic [2:0]  lvl        = 3'h0;   // questionable, message, operation
    logic [5:0]  ev         = 6'h00;  // cmd, exe, dev, no-query, overrun, local
    logic [15:0] last_code  = 16'h0000; // code of the latest queue entry
    int          fails = 0, compares = 0, srqs = 0, pushes = 0, cycles = 0;
    logic [7:0]  d;                   // scratch answer

    sbsr_top uut (.i_clk(i_clk), .i_rst(i_rst), .i_cmd(cmd), .i_cmd_valid(cmd_valid), .i_wdata(wdata),
        .o_rdata(rdata), .o_rvalid(rvalid), .i_errq_push(errq_push), .i_errq_empty(errq_empty),
        .i_ques_sum(lvl[0]), .i_msg_avail(lvl[1]), .i_oper_sum(lvl[2]), .i_opc_cmd(opc),
        .i_cmds_idle(idle), .i_read_no_query(ev[3]), .i_unread_overrun(ev[4]), .i_dev_err(ev[2]),
        .i_exe_err(ev[1]), .i_cmd_err(ev[0]), .i_go_local(ev[5]), .o_err_push(err_push),
        .o_err_code(err_code), .o_srq(srq));
    sbsr_ctrl_model ctl (.i_clk(i_clk), .i_rdata(rdata), .i_rvalid(rvalid), .o_cmd(cmd),
        .o_cmd_valid(cmd_valid), .o_wdata(wdata));

    // ---------------------------------------------------------------
    // clock, monitors and hang guard
    // ---------------------------------------------------------------
    initial
    begin
        forever #5 i_clk = ~i_clk;
    end

    always @(posedge i_clk)
    begin
        cycles++;
        if (srq === 1'b1) srqs++;
        if (err_push === 1'b1)
        begin
            pushes++;
            last_code = err_code;
        end
        if (cycles == 3000)
        begin
            fails++;
            wrap_up();
        end
    end

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic wrap_up();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic rd(input sbsr_cmd_e c, input logic [7:0] exp);
        ctl.access(c, 8'h00, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask

    task automatic wr(input sbsr_cmd_e c, input logic [7:0] v);
        ctl.access(c, v, d);
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        rd(SBSR_CMD_RD_SEL, 8'h80);
        rd(SBSR_CMD_RD_SEL, 8'h00);
        rd(SBSR_CMD_RD_SRM, 8'h00);
        rd(SBSR_CMD_RD_SEM, 8'h00);
        rd(SBSR_CMD_RD_SSB, 8'h00);
    endtask

    task automatic t_masks();
        wr(SBSR_CMD_WR_SRM, 8'hA5);
        wr(SBSR_CMD_WR_SEM, 8'h5A);
        rd(SBSR_CMD_RD_SRM, 8'hA5);
        rd(SBSR_CMD_RD_SEM, 8'h5A);
    endtask

    // each summary level in turn, masked in, then bit six alone in the mask
    task automatic t_levels();
        int unsigned pos[3] = '{SSB_QUES, SSB_MSG, SSB_OPER};
        logic [7:0] e;
        int n;
        wr(SBSR_CMD_WR_SRM, 8'hBC);
        wr(SBSR_CMD_WR_SEM, 8'h00);
        for (int k = 0; k < 3; k++)
        begin
            e = 8'h40;
            e[pos[k]] = 1'b1;
            n = srqs;
            lvl[k] = 1'b1;
            tick(4);
            rd(SBSR_CMD_RD_SSB, e);
            rd(SBSR_CMD_POLL, e);
            chk(16'(srqs - n), 16'h0001);
            lvl[k] = 1'b0;
            tick(4);
        end
        wr(SBSR_CMD_WR_SRM, 8'h40);
        n = srqs;
        lvl[0] = 1'b1;
        tick(4);
        rd(SBSR_CMD_RD_SSB, 8'h08);
        chk(16'(srqs - n), 16'h0000);
        lvl[0] = 1'b0;
        tick(4);
    endtask

    // two queue entries, each one a request, then the queue drains
    task automatic t_errq();
        int n;
        wr(SBSR_CMD_WR_SRM, 8'h04);
        n = srqs;
        errq_empty = 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            errq_push = 1'b1;
            tick(1);
            errq_push = 1'b0;
            tick(4);
        end
        rd(SBSR_CMD_RD_SSB, 8'h44);
        chk(16'(srqs - n), 16'h0002);
        errq_empty = 1'b1;
        tick(4);
        rd(SBSR_CMD_RD_SSB, 8'h00);
    endtask

    // every error kind and the local switch-over, one latch bit each
    task automatic t_errors();
        int unsigned bitp[6] = '{SEL_CME, SEL_EXE, SEL_DDE, SEL_QYE, SEL_QYE, SEL_URQ};
        logic [15:0] code[5] = '{CME_CODE, EXE_CODE, DDE_HI, QYE_CODE, QYE_CODE};
        int p;
        wr(SBSR_CMD_WR_SRM, 8'h00);
        for (int k = 0; k < 6; k++)
        begin
            p = pushes;
            ev[k] = 1'b1;
            tick(1);
            ev[k] = 1'b0;
            tick(3);
            rd(SBSR_CMD_RD_SEL, 8'(1 << bitp[k]));
            chk(16'(pushes - p), (k < 5) ? 16'h0001 : 16'h0000);
            if (k < 5) chk(last_code, code[k]);
        end
    endtask

    // completion waits for earlier commands to finish
    task automatic t_opc();
        idle = 1'b0;
        opc = 1'b1;
        tick(1);
        opc = 1'b0;
        tick(3);
        rd(SBSR_CMD_RD_SEL, 8'h00);
        idle = 1'b1;
        tick(3);
        rd(SBSR_CMD_RD_SEL, 8'h01);
    endtask

    // masked latch rise sets the summary, the read clears both
    task automatic t_esb();
        int n;
        wr(SBSR_CMD_WR_SEM, 8'h20);
        wr(SBSR_CMD_WR_SRM, 8'h20);
        n = srqs;
        ev[0] = 1'b1;
        tick(1);
        ev[0] = 1'b0;
        tick(5);
        rd(SBSR_CMD_RD_SSB, 8'h60);
        chk(16'(srqs - n), 16'h0001);
        rd(SBSR_CMD_RD_SEL, 8'h20);
        tick(4);
        rd(SBSR_CMD_RD_SSB, 8'h00);
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        tick(3);
        i_rst = 1'b0;
        t_reset();
        t_masks();
        t_levels();
        t_errq();
        t_errors();
        t_opc();
        t_esb();
        wrap_up();
    end
endmodule // sbsr_top_bench
`default_nettype wire
